// ==== rtl/iqf_pkg.sv ====
package iqf_pkg;

  // =====================================================================
  // frame geometry
  localparam int FRAME_BYTES      = 5082;
  localparam int HEAD_BYTES       = 6;
  localparam int CHUNK_BYTES      = 508;
  localparam int LAST_CHUNK_BYTES = 504;
  localparam int NUM_CHUNKS       = 10;
  localparam int GROUP_BYTES      = 24;  // eight 3-byte mixed groups
  localparam int RAD_GROUPS       = 5;   // groups 0..4 carry radiometry
  localparam int LAST_GROUP       = 7;   // groups 5..7 carry the time tag
  localparam int GROUP_LAST_PHASE = 2;

  // =====================================================================
  // head byte positions (0-based) and fixed contents
  localparam int        HEAD_ID_POS     = 0;
  localparam int        HEAD_STATUS_POS = 3;
  localparam logic [7:0] ID_VALUE       = 8'hB7;
  localparam int        STATUS_SEL_LSB  = 4;

  // =====================================================================
  // field widths and reset values
  localparam int        RAD_W       = 40;
  localparam int        TAG_W       = 24;
  localparam int        SEL_W       = 3;
  localparam logic [TAG_W-1:0] TAG_RESET = 24'h000000;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic [7:0] data;
    logic       sof;
    logic       eof;
  } iqf_beat_t;

  typedef struct packed {
    logic [SEL_W-1:0]                 input_sel;
    logic [NUM_CHUNKS-1:0][RAD_W-1:0] rad;
  } iqf_fields_t;

endpackage

// ==== rtl/iqf_time_tag.sv ====
`timescale 1ns/1ps

module iqf_time_tag
  import iqf_pkg::*;
#(
  parameter int TAG_BITS = TAG_W
) (
  input  wire logic                core_clk_i,
  input  wire logic                srst_i,
  input  wire logic                clear_i,
  input  wire logic                tick_i,
  output logic [TAG_BITS-1:0]      tag_o
);

  initial begin
    if (TAG_BITS != TAG_W) $error("iqf_time_tag: TAG_BITS must equal TAG_W");
  end

  logic [TAG_BITS-1:0] tag_reg;

  // =====================================================================
  // free running tag, cleared by reset or a start command
  always_ff @(posedge core_clk_i) begin
    if (srst_i || clear_i) begin
      tag_reg <= TAG_RESET;
    end else if (tick_i) begin
      tag_reg <= tag_reg + 1'b1;
    end
  end

  assign tag_o = tag_reg;

  tag_step_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (tick_i && !clear_i) |=> (tag_reg == $past(tag_reg) + 1'b1))
    else $error("time tag did not step on tick");

endmodule // iqf_time_tag

// ==== rtl/iqf_framer.sv ====
`timescale 1ns/1ps

// Overview of operation
// - frame is exactly 5082 unsigned bytes
// - identifier byte 1, status byte 4
// - bytes 2,3 and 5,6 hold first sample pair
// - radiometry high byte first, bytes 7 step 3
// - radiometry field repeats every 508 bytes, own value per chunk
// - time tag high byte first, bytes 22 step 3
// - time tag repeats every 508 bytes
// - I then Q samples fill remaining bytes
// - chunk: eight mixed groups, then contiguous samples
// - sample positions follow chunk position formula
// - tenth chunk is 504 bytes long
// - identifier byte is constant B7
// - status holds input select bits 6:4
// - time tag runs across frames, start clears
module iqf_framer
  import iqf_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire iqf_fields_t fields_i,
  input  wire logic [15:0] samp_data_i,
  input  wire logic        samp_valid_i,
  output logic             samp_ready_o,
  output iqf_beat_t        out_beat_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic             running_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_CHUNK} iqf_state_t;

  iqf_state_t        state_reg;
  logic [2:0]        hd_reg;
  logic [3:0]        chunk_reg;
  logic [8:0]        off_reg;
  logic [1:0]        ph_reg;
  logic [2:0]        grp_reg;
  logic              low_pending_reg;
  logic [7:0]        samp_lo_reg;
  logic              run_reg;
  iqf_fields_t       fields_reg;
  logic [TAG_W-1:0]  tag_base_reg;
  iqf_beat_t         beat_reg;
  logic              valid_reg;
  logic [12:0]       acc_cnt_reg;

  logic              is_field;
  logic [7:0]        field_byte;
  logic [RAD_W-1:0]  rad_word;
  logic [TAG_W-1:0]  tag_word;
  logic [TAG_W-1:0]  tag_now;
  logic              in_groups;
  logic              need_sample;
  logic              slot_free;
  logic              load;
  logic              sof_now;
  logic              eof_now;
  logic              chunk_end;
  logic              tick;

  // =====================================================================
  // position decode
  assign in_groups = (off_reg < 9'(GROUP_BYTES));
  assign sof_now   = (state_reg == ST_HEAD) && (hd_reg == 3'(HEAD_ID_POS));
  assign eof_now   = (state_reg == ST_CHUNK) && (chunk_reg == 4'(NUM_CHUNKS - 1))
                     && (off_reg == 9'(LAST_CHUNK_BYTES - 1));
  assign chunk_end = (off_reg == 9'(CHUNK_BYTES - 1));
  assign rad_word  = fields_reg.rad[chunk_reg];
  assign tag_word  = tag_base_reg + TAG_W'(chunk_reg);

  // field bytes versus sample bytes
  always_comb begin
    is_field   = 1'b0;
    field_byte = 8'h00;
    case (state_reg)
      ST_HEAD: begin
        if (hd_reg == 3'(HEAD_ID_POS)) begin
          is_field   = 1'b1;
          field_byte = ID_VALUE;
        end else if (hd_reg == 3'(HEAD_STATUS_POS)) begin
          is_field   = 1'b1;
          field_byte = 8'({fields_reg.input_sel, 4'h0});
        end
      end
      ST_CHUNK: begin
        if (in_groups && (ph_reg == 2'h0)) begin
          is_field = 1'b1;
          if (grp_reg < 3'(RAD_GROUPS)) begin
            field_byte = 8'(rad_word >> (6'h08 * {3'h0, 3'h4 - grp_reg}));
          end else begin
            field_byte = 8'(tag_word >> (5'h08 * {2'h0, 3'(LAST_GROUP) - grp_reg}));
          end
        end
      end
      default: begin
        is_field   = 1'b0;
        field_byte = 8'h00;
      end
    endcase
  end

  // =====================================================================
  // transfer handshake
  assign need_sample  = (state_reg != ST_IDLE) && !is_field && !low_pending_reg;
  assign slot_free    = !valid_reg || out_ready_i;
  assign load         = (state_reg != ST_IDLE) && slot_free
                        && (!need_sample || samp_valid_i);
  assign samp_ready_o = slot_free && need_sample;
  assign tick         = load && (state_reg == ST_CHUNK) && (off_reg == 9'h000);

  // output byte register, held while the consumer stalls
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      beat_reg  <= '0;
      valid_reg <= 1'b0;
    end else if (load) begin
      beat_reg.data <= is_field ? field_byte
                     : (low_pending_reg ? samp_lo_reg : samp_data_i[15:8]);
      beat_reg.sof  <= sof_now;
      beat_reg.eof  <= eof_now;
      valid_reg     <= 1'b1;
    end else if (out_ready_i) begin
      valid_reg <= 1'b0;
    end
  end

  // sample low byte kept until its slot comes up
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      low_pending_reg <= 1'b0;
      samp_lo_reg     <= 8'h00;
    end else if (load && !is_field) begin
      low_pending_reg <= !low_pending_reg;
      if (!low_pending_reg) begin
        samp_lo_reg <= samp_data_i[7:0];
      end
    end
  end

  // =====================================================================
  // run control: start wins over stop
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      run_reg <= 1'b0;
    end else if (start_i) begin
      run_reg <= 1'b1;
    end else if (stop_i) begin
      run_reg <= 1'b0;
    end
  end

  // frame-wide snapshot of fields and tag base
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      fields_reg   <= '0;
      tag_base_reg <= TAG_RESET;
    end else if (load && sof_now) begin
      fields_reg   <= fields_i;
      tag_base_reg <= tag_now;
    end
  end

  // =====================================================================
  // byte position sequencer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      hd_reg    <= 3'h0;
      chunk_reg <= 4'h0;
      off_reg   <= 9'h000;
      ph_reg    <= 2'h0;
      grp_reg   <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          hd_reg <= 3'h0;
          if (run_reg) begin
            state_reg <= ST_HEAD;
          end
        end
        ST_HEAD: begin
          if (load) begin
            if (hd_reg == 3'(HEAD_BYTES - 1)) begin
              state_reg <= ST_CHUNK;
              chunk_reg <= 4'h0;
              off_reg   <= 9'h000;
              ph_reg    <= 2'h0;
              grp_reg   <= 3'h0;
            end else begin
              hd_reg <= hd_reg + 3'h1;
            end
          end
        end
        ST_CHUNK: begin
          if (load) begin
            if (eof_now) begin
              state_reg <= run_reg ? ST_HEAD : ST_IDLE;
              hd_reg    <= 3'h0;
            end else if (chunk_end) begin
              chunk_reg <= chunk_reg + 4'h1;
              off_reg   <= 9'h000;
              ph_reg    <= 2'h0;
              grp_reg   <= 3'h0;
            end else begin
              off_reg <= off_reg + 9'h001;
              if (ph_reg == 2'(GROUP_LAST_PHASE)) begin
                ph_reg  <= 2'h0;
                grp_reg <= grp_reg + 3'h1;
              end else begin
                ph_reg <= ph_reg + 2'h1;
              end
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // time tag counter
  iqf_time_tag #(
    .TAG_BITS (TAG_W)
  ) u_tag (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .clear_i    (start_i),
    .tick_i     (tick),
    .tag_o      (tag_now)
  );

  assign out_beat_o  = beat_reg;
  assign out_valid_o = valid_reg;
  assign running_o   = run_reg;

  // =====================================================================
  // accepted byte count, checking only
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      acc_cnt_reg <= 13'h0000;
    end else if (valid_reg && out_ready_i) begin
      acc_cnt_reg <= beat_reg.eof ? 13'h0000 : acc_cnt_reg + 13'h0001;
    end
  end

  frame_length_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (valid_reg && out_ready_i && beat_reg.eof) |-> (acc_cnt_reg == 13'(FRAME_BYTES - 1)))
    else $error("frame length is not 5082 bytes");

  id_byte_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (valid_reg && beat_reg.sof) |-> (beat_reg.data == ID_VALUE && acc_cnt_reg == 13'h0000))
    else $error("start of frame byte is not the identifier");

  status_bits_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (valid_reg && acc_cnt_reg == 13'(HEAD_STATUS_POS))
    |-> (beat_reg.data[7] == 1'b0 && beat_reg.data[3:0] == 4'h0))
    else $error("status byte carries bits outside 6:4");

  last_chunk_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (load && (state_reg == ST_CHUNK) && (chunk_reg == 4'(NUM_CHUNKS - 1)))
    |-> (off_reg <= 9'(LAST_CHUNK_BYTES - 1)))
    else $error("tenth chunk runs past 504 bytes");

  output_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (valid_reg && !out_ready_i) |=> (valid_reg && $stable(beat_reg)))
    else $error("output changed while consumer stalled");

  group_field_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ((state_reg == ST_CHUNK) && in_groups && (ph_reg == 2'h0)) |-> !samp_ready_o)
    else $error("sample taken in a field slot");

  sample_pair_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (samp_ready_o && samp_valid_i) |=> (low_pending_reg && !samp_ready_o))
    else $error("low byte slot skipped after high byte");

  field_latch_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_reg == ST_CHUNK) |=> $stable(fields_reg) && $stable(tag_base_reg))
    else $error("frame fields changed mid frame");

endmodule // iqf_framer

// ==== verif/iqf_sink.sv ====
`timescale 1ns/1ps

module iqf_sink
  import iqf_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      srst_i,
  input  wire iqf_beat_t beat_i,
  input  wire logic      valid_i,
  input  wire logic      stall_i,
  output logic           ready_o
);
  // ======
  // frame capture
  logic [7:0] mem [FRAME_BYTES];
  iqf_beat_t  held;
  logic       was_stalled = 0;
  int         idx = 0, len = 0, frames = 0, mark_err = 0, hold_err = 0, cyc = 0;

  initial ready_o = 1'b1;

  // take bytes, rebuild frame, watch markers and stalls
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      idx = 0;
      was_stalled = 0;
    end else begin
      if (was_stalled && (!valid_i || beat_i !== held)) hold_err++;
      was_stalled = valid_i && !ready_o;
      held = beat_i;
      if (valid_i && ready_o) begin
        if (beat_i.sof !== (idx == 0) || beat_i.eof !== (idx == FRAME_BYTES-1)) mark_err++;
        if (idx < FRAME_BYTES) mem[idx] = beat_i.data;
        idx++;
        if (beat_i.eof) begin
          len = idx;
          idx = 0;
          frames++;
        end
      end
    end
    cyc++;
    #1 ready_o = !stall_i || (cyc % 3 != 0); // slow consumer when asked
  end
endmodule // iqf_sink

// ==== verif/iq_radiometry_frame_interleaver_tb_top.sv ====
`timescale 1ns/1ps

module iq_radiometry_frame_interleaver_tb_top;
  import iqf_pkg::*;
  // ======
  // stimulus and clock
  logic        core_clk_i = 0, srst_i = 1, start_i = 0, stop_i = 0;
  logic        samp_valid_i = 0, samp_ready_o, out_valid_o, out_ready_i;
  logic        running_o, gap = 0, stall = 0, take;
  logic [15:0] samp_data_i = 0;
  iqf_fields_t fields_i = '0;
  iqf_beat_t   out_beat_o;
  int          err_count = 0, checks = 0, cyc = 0, w = 0, wb;

  iqf_framer dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .start_i(start_i),
    .stop_i(stop_i), .fields_i(fields_i), .samp_data_i(samp_data_i),
    .samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o), .out_beat_o(out_beat_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .running_o(running_o));
  iqf_sink sink (.core_clk_i(core_clk_i), .srst_i(srst_i), .beat_i(out_beat_o),
    .valid_i(out_valid_o), .stall_i(stall), .ready_o(out_ready_i));

  // clock and hang guard
  initial forever #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      end_sim;
    end
  end

  // sample word source, optional gaps
  always @(posedge core_clk_i) begin
    take = samp_valid_i & samp_ready_o;
    #1;
    if (take) w++;
    samp_data_i = samp(w);
    samp_valid_i = !gap || cyc % 5 != 2;
  end

  function automatic logic [15:0] samp(int n);
    return 16'(n * 40503 + 291);
  endfunction

  function automatic logic [39:0] rad(int f, int c);
    return {8'hC3, 8'(f), 8'(c), 16'h9A3E};
  endfunction

  task automatic step(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic chk(string n, logic [39:0] e, logic [39:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic set_fields(int f);
    fields_i.input_sel = 3'(f);
    for (int c = 0; c < NUM_CHUNKS; c++) fields_i.rad[c] = rad(f, c);
  endtask

  task automatic pulse(bit st);
    if (st) start_i = 1; else stop_i = 1;
    step(1);
    start_i = 0;
    stop_i = 0;
  endtask

  task automatic wait_frame();
    int n;
    n = sink.frames;
    for (int i = 0; i < 20000 && sink.frames == n; i++) step(1);
    if (sink.frames == n) begin
      err_count++;
      $display("CHECK FAILED frame end exp %0d got %0d", n + 1, sink.frames);
      end_sim();
    end
  endtask

  // ======
  // frame judge
  task automatic check_frame(int f, int tag, int b);
    int p, km, v, d;
    logic [39:0] r;
    logic [23:0] t;
    logic [7:0]  hi, lo;
    chk("length", FRAME_BYTES, sink.len);
    chk("markers", 0, sink.mark_err + sink.hold_err);
    chk("ident", ID_VALUE, sink.mem[0]);
    chk("status", {1'b0, 3'(f), 4'h0}, sink.mem[3]);
    for (int c = 0; c < NUM_CHUNKS; c++) begin
      r = rad(f, c);
      t = 24'(tag + c);
      for (int i = 0; i < 5; i++) chk("rad", r[39-8*i -: 8], sink.mem[6+508*c+3*i]);
      for (int i = 0; i < 3; i++) chk("tag", t[23-8*i -: 8], sink.mem[21+508*c+3*i]);
    end
    for (int k = 1; k <= 1250; k++) begin
      km = (k + 123) % 125;
      p = (k == 1) ? 1 : 508*((k+123-km)/125-1) + ((km < 4) ? 7 + 6*km : 14 + 4*km);
      d = (k == 1 || km < 4) ? 3 : 2;
      for (int q = 0; q < 2; q++) begin
        hi = sink.mem[p + q*d];
        lo = sink.mem[p + q*d + 1];
        chk("sample", samp(b + 2*k - 2 + q), {hi, lo});
        v = 256*hi + lo - (hi > 127 ? 65536 : 0);
        chk("signed", 40'($signed(samp(b + 2*k - 2 + q))), 40'(v));
      end
    end
  endtask

  task automatic check_idle();
    step(20);
    chk("running", 0, running_o);
    chk("valid", 0, out_valid_o);
  endtask

  // ======
  // scenarios
  task automatic scen_run8();
    wb = w;
    set_fields(0);
    pulse(1);
    for (int f = 0; f < 8; f++) begin
      step(100);
      if (f < 7) set_fields(f + 1); else pulse(0);
      wait_frame();
      check_frame(f, 10*f, wb + 2500*f);
    end
    check_idle();
  endtask

  task automatic scen_reset();
    set_fields(1);
    pulse(1);
    step(300);
    srst_i = 1;
    step(2);
    chk("rst valid", 0, out_valid_o);
    chk("rst ready", 0, samp_ready_o);
    chk("rst run", 0, running_o);
    srst_i = 0;
    step(2);
    chk("post rst valid", 0, out_valid_o);
    chk("post rst ready", 0, samp_ready_o);
  endtask

  task automatic scen_stall();
    gap = 1;
    stall = 1;
    step(2);
    wb = w;
    set_fields(3);
    pulse(1);
    step(5);
    pulse(0);
    wait_frame();
    check_frame(3, 0, wb);
    check_idle();
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    step(8);
    srst_i = 0;
    scen_run8();
    scen_reset();
    scen_stall();
    end_sim();
  end
endmodule // iq_radiometry_frame_interleaver_tb_top
